// ==== hw/amgc_defines.svh ====
// register offsets, field positions, reset values and codes for the input selector control
`ifndef AMGC_DEFINES_SVH
`define AMGC_DEFINES_SVH

`define AMGC_ADDR_W 3
`define AMGC_OFF_CTRL 3'h0
`define AMGC_OFF_CFG 3'h1
`define AMGC_OFF_PAIR 3'h2
`define AMGC_OFF_CHSEL 3'h3
`define AMGC_OFF_PINSEL 3'h4
`define AMGC_OFF_STATUS 3'h5
`define AMGC_OFF_RESULT_LO 3'h6
`define AMGC_OFF_RESULT_HI 3'h7

`define AMGC_CTRL_EN_BIT 7
`define AMGC_CFG_GAIN_LSB 0
`define AMGC_PAIR_AIN01_BIT 0
`define AMGC_PAIR_AIN23_BIT 1
`define AMGC_PAIR_HV2C_BIT 2
`define AMGC_PAIR_P3_BIT 3
`define AMGC_PAIR_MASK 8'h0F

`define AMGC_RST_CTRL 8'h00
`define AMGC_RST_CFG 8'h06
`define AMGC_RST_PAIR 8'h00
`define AMGC_RST_CHSEL 8'h00
`define AMGC_RST_PINSEL 8'h00

`define AMGC_GAIN_1 3'h6
`define AMGC_GAIN_2 3'h1
`define AMGC_GAIN_4 3'h2
`define AMGC_GAIN_8 3'h3
`define AMGC_GAIN_16 3'h4
`define AMGC_GAIN_HALF 3'h0

`endif

// ==== hw/amgc_pkg.sv ====
// types shared by the input selector control files
`default_nettype none
package amgc_pkg;
    typedef enum logic [3:0] {
        AMGC_SRC_AIN0, AMGC_SRC_AIN1, AMGC_SRC_AIN2, AMGC_SRC_AIN3,
        AMGC_SRC_HIGH_VOLTAGE_DIFF_AMP, AMGC_SRC_AGND, AMGC_SRC_P3EVEN, AMGC_SRC_P3ODD,
        AMGC_SRC_TEMP
    } amgc_src_t;
    typedef struct packed {
        amgc_src_t pos_src;
        amgc_src_t neg_src;
        logic diff;
        logic hv_ref_neg;
        logic twos_comp;
    } amgc_route_t;
    typedef struct packed {
        logic power_on;
        logic [2:0] gain_code;
        logic [7:0] p3_even_en;
        logic [7:0] p3_odd_en;
    } amgc_analog_t;
endpackage : amgc_pkg
`default_nettype wire

// ==== hw/amgc_route.sv ====
// channel route decode from channel select and pair configuration
`include "amgc_defines.svh"
`default_nettype none
module amgc_route (
    input wire logic [3:0] chan,
    input wire logic [3:0] pair_cfg,
    output amgc_pkg::amgc_route_t route
);
    import amgc_pkg::*;

    // -----------------------------------------
    // pair decode
    // -----------------------------------------
    wire logic pair01 = pair_cfg[`AMGC_PAIR_AIN01_BIT];
    wire logic pair23 = pair_cfg[`AMGC_PAIR_AIN23_BIT];
    wire logic hvdiff = pair_cfg[`AMGC_PAIR_HV2C_BIT];
    wire logic p3pair = pair_cfg[`AMGC_PAIR_P3_BIT];
    wire logic hi_code = chan[3];
    wire logic [2:0] lo = chan[2:0];

    // nine positions; a paired input routes as plus/minus of its pair
    always_comb begin
        route = '{pos_src: AMGC_SRC_AGND, neg_src: AMGC_SRC_AGND, diff: 1'b0,
                  hv_ref_neg: 1'b0, twos_comp: 1'b0};
        if (hi_code) begin
            route.pos_src = AMGC_SRC_TEMP;
        end else begin
            unique case (lo)
                3'd0, 3'd1: begin
                    if (pair01) begin
                        route.pos_src = AMGC_SRC_AIN0;
                        route.neg_src = AMGC_SRC_AIN1;
                        route.diff = 1'b1;
                    end else begin
                        route.pos_src = lo[0] ? AMGC_SRC_AIN1 : AMGC_SRC_AIN0;
                    end
                end
                3'd2, 3'd3: begin
                    if (pair23) begin
                        route.pos_src = AMGC_SRC_AIN2;
                        route.neg_src = AMGC_SRC_AIN3;
                        route.diff = 1'b1;
                    end else begin
                        route.pos_src = lo[0] ? AMGC_SRC_AIN3 : AMGC_SRC_AIN2;
                    end
                end
                3'd4, 3'd5: begin
                    if (hvdiff) begin
                        route.pos_src = AMGC_SRC_HIGH_VOLTAGE_DIFF_AMP;
                        route.hv_ref_neg = 1'b1;
                        route.diff = 1'b1;
                    end else begin
                        route.pos_src = lo[0] ? AMGC_SRC_AGND : AMGC_SRC_HIGH_VOLTAGE_DIFF_AMP;
                    end
                end
                default: begin
                    if (p3pair) begin
                        route.pos_src = AMGC_SRC_P3EVEN;
                        route.neg_src = AMGC_SRC_P3ODD;
                        route.diff = 1'b1;
                    end else begin
                        route.pos_src = lo[0] ? AMGC_SRC_P3ODD : AMGC_SRC_P3EVEN;
                    end
                end
            endcase
        end
        route.twos_comp = route.diff;
    end
endmodule // amgc_route
`default_nettype wire

// ==== hw/amgc_ctrl.sv ====
// register file and control outputs for the converter input selector and gain
`include "amgc_defines.svh"
`default_nettype none
module amgc_ctrl (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [`AMGC_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] conv_result,
    input wire logic conv_done,
    output logic [7:0] reg_rdata,
    output amgc_pkg::amgc_route_t route_out,
    output amgc_pkg::amgc_analog_t analog_out
);
    import amgc_pkg::*;

    // -----------------------------------------
    // registers
    // -----------------------------------------
    logic [7:0] ctrl_reg;
    logic [7:0] cfg_reg;
    logic [3:0] pair_reg;
    logic [3:0] chsel_reg;
    logic [7:0] pinsel_reg;
    logic [11:0] result_reg;
    logic result_fmt;
    logic [7:0] next_rdata;
    amgc_route_t route_dec;

    // -----------------------------------------
    // write decode
    // -----------------------------------------
    wire logic wr_ctrl = reg_wr && reg_addr == `AMGC_OFF_CTRL;
    wire logic wr_cfg = reg_wr && reg_addr == `AMGC_OFF_CFG;
    wire logic wr_pair = reg_wr && reg_addr == `AMGC_OFF_PAIR;
    wire logic wr_chsel = reg_wr && reg_addr == `AMGC_OFF_CHSEL;
    wire logic wr_pinsel = reg_wr && reg_addr == `AMGC_OFF_PINSEL;
    wire logic enabled = ctrl_reg[`AMGC_CTRL_EN_BIT];

    // control and config registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= `AMGC_RST_CTRL;
            cfg_reg <= `AMGC_RST_CFG;
        end else begin
            if (wr_ctrl) ctrl_reg <= reg_wdata;
            if (wr_cfg) cfg_reg <= reg_wdata;
        end
    end

    // selector registers, writable any time, cleared to zero by reset
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pair_reg <= 4'h0;
            chsel_reg <= 4'h0;
            pinsel_reg <= `AMGC_RST_PINSEL;
        end else begin
            if (wr_pair) pair_reg <= reg_wdata[3:0];
            if (wr_chsel) chsel_reg <= reg_wdata[3:0];
            if (wr_pinsel) pinsel_reg <= reg_wdata;
        end
    end

    // -----------------------------------------
    // route decode
    // -----------------------------------------
    amgc_route u_route (
        .chan(chsel_reg),
        .pair_cfg(pair_reg),
        .route(route_dec)
    );

    // result capture; format tagged by route at completion
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_reg <= 12'h000;
            result_fmt <= 1'b0;
        end else if (conv_done && enabled) begin
            result_reg <= conv_result;
            result_fmt <= route_dec.twos_comp;
        end
    end

    // -----------------------------------------
    // read mux
    // -----------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            `AMGC_OFF_CTRL: next_rdata = ctrl_reg;
            `AMGC_OFF_CFG: next_rdata = cfg_reg;
            `AMGC_OFF_PAIR: next_rdata = {4'h0, pair_reg};
            `AMGC_OFF_CHSEL: next_rdata = {4'h0, chsel_reg};
            `AMGC_OFF_PINSEL: next_rdata = pinsel_reg;
            `AMGC_OFF_STATUS: next_rdata = {6'h00, result_fmt, route_dec.diff};
            `AMGC_OFF_RESULT_LO: next_rdata = result_reg[7:0];
            `AMGC_OFF_RESULT_HI: next_rdata = {{4{result_fmt & result_reg[11]}},
                                               result_reg[11:8]};
        endcase
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end

    // -----------------------------------------
    // analog control outputs
    // -----------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            route_out <= '{pos_src: AMGC_SRC_AIN0, neg_src: AMGC_SRC_AGND, diff: 1'b0,
                           hv_ref_neg: 1'b0, twos_comp: 1'b0};
            analog_out <= '{power_on: 1'b0, gain_code: `AMGC_GAIN_1,
                            p3_even_en: 8'h00, p3_odd_en: 8'h00};
        end else begin
            route_out <= route_dec;
            analog_out.power_on <= enabled;
            analog_out.gain_code <= cfg_reg[`AMGC_CFG_GAIN_LSB +: 3];
            analog_out.p3_even_en <= pinsel_reg & 8'h55;
            analog_out.p3_odd_en <= pinsel_reg & 8'hAA;
        end
    end

    // -----------------------------------------
    // assertions
    // -----------------------------------------
    a_power_follows_en: assert property (@(posedge sys_clk) disable iff (!arst_n)
        analog_out.power_on == $past(enabled))
        else $error("power does not follow enable");
    a_shutdown_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !enabled ##1 !enabled |-> !analog_out.power_on)
        else $error("power on while disabled");
    a_pair_upper_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        reg_rd && reg_addr == `AMGC_OFF_PAIR |=> reg_rdata[7:4] == 4'h0)
        else $error("pair upper bits not zero");
    // a second config write right behind the first legally overrides it
    a_gain_tracks: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_cfg ##1 !wr_cfg |=> analog_out.gain_code == $past(reg_wdata[2:0], 2))
        else $error("gain not applied");
    a_pair_write: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wr_pair |=> pair_reg == $past(reg_wdata[3:0]))
        else $error("pair config not updated");
    a_p3_diff: assert property (@(posedge sys_clk) disable iff (!arst_n)
        pair_reg[3] && chsel_reg[3:1] == 3'b011 |->
        route_dec.pos_src == AMGC_SRC_P3EVEN && route_dec.neg_src == AMGC_SRC_P3ODD)
        else $error("port pair route wrong");
    a_ain01_diff: assert property (@(posedge sys_clk) disable iff (!arst_n)
        chsel_reg[3:1] == 3'b000 |-> route_dec.diff == pair_reg[0])
        else $error("input pair 0/1 route wrong");
    a_twos_fmt: assert property (@(posedge sys_clk) disable iff (!arst_n)
        conv_done && enabled |=> result_fmt == $past(route_dec.diff))
        else $error("result format wrong");
    a_pin_split: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (analog_out.p3_even_en & analog_out.p3_odd_en) == 8'h00)
        else $error("even and odd pin sets overlap");
    a_hv_select: assert property (@(posedge sys_clk) disable iff (!arst_n)
        chsel_reg == 4'h4 |-> route_dec.pos_src == AMGC_SRC_HIGH_VOLTAGE_DIFF_AMP)
        else $error("hv amplifier not selected");

    c_enable_on: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(enabled));
    c_diff_conv: cover property (@(posedge sys_clk) disable iff (!arst_n)
        conv_done && enabled && route_dec.diff);
    c_temp_sel: cover property (@(posedge sys_clk) disable iff (!arst_n)
        route_dec.pos_src == AMGC_SRC_TEMP);
endmodule // amgc_ctrl
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking testbench for the converter input selector and gain control
`include "amgc_defines.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import amgc_pkg::*;

    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [11:0] conv_result = 12'h000;
    logic conv_done = 1'b0;
    logic [7:0] reg_rdata;
    amgc_route_t route_out;
    amgc_analog_t analog_out;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [2:0] gains [6] = '{`AMGC_GAIN_HALF, `AMGC_GAIN_2, `AMGC_GAIN_4,
                              `AMGC_GAIN_8, `AMGC_GAIN_16, `AMGC_GAIN_1};

    amgc_ctrl i_amgc_ctrl (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .conv_result(conv_result),
        .conv_done(conv_done),
        .reg_rdata(reg_rdata),
        .route_out(route_out),
        .analog_out(analog_out)
    );

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    // a hang counts as a mismatch and ends the run
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // shared tasks and expectation functions
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("totals: %0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask

    // outputs lag a write by two edges
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic conv(input logic [11:0] r);
        @(posedge sys_clk);
        conv_done <= 1'b1;
        conv_result <= r;
        @(posedge sys_clk);
        conv_done <= 1'b0;
        conv_result <= ~r; // word no longer held
    endtask

    // expected route for a channel code and pair setting
    function automatic amgc_route_t exp_route(input logic [3:0] c, input logic [3:0] p);
        amgc_route_t r;
        r.pos_src = amgc_src_t'({1'b0, c[2:0]});
        r.neg_src = AMGC_SRC_AGND;
        r.diff = 1'b1;
        r.hv_ref_neg = 1'b0;
        if (c[3]) begin
            r.pos_src = AMGC_SRC_TEMP;
            r.diff = 1'b0;
        end else if (c[2:1] == 2'b00 && p[0]) begin
            r.pos_src = AMGC_SRC_AIN0;
            r.neg_src = AMGC_SRC_AIN1;
        end else if (c[2:1] == 2'b01 && p[1]) begin
            r.pos_src = AMGC_SRC_AIN2;
            r.neg_src = AMGC_SRC_AIN3;
        end else if (c[2:1] == 2'b10 && p[2]) begin
            r.pos_src = AMGC_SRC_HIGH_VOLTAGE_DIFF_AMP;
            r.hv_ref_neg = 1'b1;
        end else if (c[2:1] == 2'b11 && p[3]) begin
            r.pos_src = AMGC_SRC_P3EVEN;
            r.neg_src = AMGC_SRC_P3ODD;
        end else begin
            r.diff = 1'b0;
        end
        r.twos_comp = r.diff;
        return r;
    endfunction

    // minus side is left open when the high-voltage reference is used
    function automatic logic [15:0] rkey(input amgc_route_t r);
        return {5'h00, r.pos_src, r.hv_ref_neg ? 4'h0 : r.neg_src, r.diff, r.hv_ref_neg,
                r.twos_comp};
    endfunction

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] v;
        logic [11:0] r;
        amgc_route_t e;
        void'($urandom(32'hfc65));
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        #1;
        chk({15'h0, analog_out.power_on}, 16'h0000);
        chk({13'h0, analog_out.gain_code}, {13'h0, `AMGC_GAIN_1});
        chk(rkey(route_out), rkey(exp_route(4'h0, 4'h0)));
        rdchk(`AMGC_OFF_CFG, `AMGC_RST_CFG);
        // read data stand one cycle only, then fall back to zero
        @(posedge sys_clk);
        #1;
        chk({8'h00, reg_rdata}, 16'h0000);
        rdchk(`AMGC_OFF_PAIR, `AMGC_RST_PAIR);
        rdchk(`AMGC_OFF_CHSEL, `AMGC_RST_CHSEL);
        rdchk(`AMGC_OFF_PINSEL, `AMGC_RST_PINSEL);
        $display("test reset values done");
        wr(`AMGC_OFF_CTRL, 8'h80);
        settle();
        chk({15'h0, analog_out.power_on}, 16'h0001);
        foreach (gains[i]) begin
            wr(`AMGC_OFF_CFG, {5'h00, gains[i]});
            settle();
            chk({13'h0, analog_out.gain_code}, {13'h0, gains[i]});
        end
        wr(`AMGC_OFF_CTRL, 8'h00);
        settle();
        chk({15'h0, analog_out.power_on}, 16'h0000);
        $display("test enable and gain done");
        for (int p = 0; p < 16; p++) begin
            v = 8'($urandom);
            wr(`AMGC_OFF_PAIR, {v[7:4], 4'(p)});
            rdchk(`AMGC_OFF_PAIR, {4'h0, 4'(p)});
            for (int c = 0; c < 16; c++) begin
                wr(`AMGC_OFF_CHSEL, {4'h0, 4'(c)});
                settle();
                e = exp_route(4'(c), 4'(p));
                chk(rkey(route_out), rkey(e));
                rdchk(`AMGC_OFF_STATUS, {7'h00, e.diff});
            end
        end
        $display("test channel routing done");
        for (int k = 0; k < 9; k++) begin
            v = (k == 0) ? 8'hff : 8'($urandom);
            wr(`AMGC_OFF_PINSEL, v);
            rdchk(`AMGC_OFF_PINSEL, v);
            settle();
            chk({8'h00, analog_out.p3_even_en}, {8'h00, v & 8'h55});
            chk({8'h00, analog_out.p3_odd_en}, {8'h00, v & 8'haa});
        end
        $display("test port pin select done");
        wr(`AMGC_OFF_CTRL, 8'h80);
        wr(`AMGC_OFF_PAIR, 8'h01);
        wr(`AMGC_OFF_CHSEL, 8'h00);
        settle();
        for (int k = 0; k < 4; k++) begin
            r = (k == 0) ? 12'h800 : 12'($urandom);
            conv(r);
            rdchk(`AMGC_OFF_RESULT_LO, r[7:0]);
            rdchk(`AMGC_OFF_RESULT_HI, {{4{r[11]}}, r[11:8]});
        end
        wr(`AMGC_OFF_PAIR, 8'h00);
        settle();
        r = 12'($urandom) | 12'h800;
        conv(r);
        rdchk(`AMGC_OFF_RESULT_HI, {4'h0, r[11:8]});
        wr(`AMGC_OFF_CTRL, 8'h00);
        conv(~r);
        rdchk(`AMGC_OFF_RESULT_LO, r[7:0]);
        wr(`AMGC_OFF_STATUS, 8'hff);
        rdchk(`AMGC_OFF_STATUS, 8'h00);
        $display("test conversion result done");
        finish_test();
    end
endmodule // tb
`default_nettype wire
